// ### wot_consts.vh
`ifndef WOT_CONSTS_VH
`define WOT_CONSTS_VH

// Register byte offsets
`define WOT_ADDR_CTRL        6'h00
`define WOT_ADDR_STATUS      6'h04
`define WOT_ADDR_TIMEBASE    6'h08
`define WOT_ADDR_DIVISOR     6'h0c
`define WOT_ADDR_START_CFG   6'h10
`define WOT_ADDR_START_DELAY 6'h14
`define WOT_ADDR_START_TIME  6'h18
`define WOT_ADDR_HOLD_CFG    6'h1c
`define WOT_ADDR_ROUTE       6'h20
`define WOT_ADDR_TIME_NOW    6'h24
`define WOT_ADDR_UPD_COUNT   6'h28

// Control command bits
`define WOT_CTRL_ARM         0
`define WOT_CTRL_SW_START    1
`define WOT_CTRL_STOP        2

// Timebase field layout and codes
`define WOT_TB_SEL_LSB       0
`define WOT_TB_SEL_MSB       1
`define WOT_TB_STROBE_EXT    2
`define WOT_TB_13M1072       2'h0
`define WOT_TB_12M8          2'h1
`define WOT_TB_10M           2'h2
`define WOT_TB_EXTERNAL      2'h3

// Phase increments: f_base / 25 MHz * 2^32
`define WOT_INC_13M1072      32'h8637bd05
`define WOT_INC_12M8         32'h83126e97
`define WOT_INC_10M          32'h66666666

// Start source codes
`define WOT_SRC_SOFTWARE     3'h0
`define WOT_SRC_TERMINAL     3'h1
`define WOT_SRC_IN_REF       3'h2
`define WOT_SRC_IN_START     3'h3
`define WOT_SRC_TIME         3'h4

// Reset values
`define WOT_TIMEBASE_RST     32'h00000000
`define WOT_DIVISOR_RST      32'h00000001
`define WOT_START_CFG_RST    32'h00000000
`define WOT_HOLD_CFG_RST     32'h00000000
`define WOT_ROUTE_RST        32'h00000000

// Sequencer states
`define WOT_ST_IDLE          2'h0
`define WOT_ST_ARMED         2'h1
`define WOT_ST_DELAY         2'h2
`define WOT_ST_RUN           2'h3

// AXI responses
`define WOT_RESP_OKAY        2'h0
`define WOT_RESP_SLVERR      2'h2

`endif

// ### wot_sync.v
`timescale 1ns/1ps
`default_nettype none
module wot_sync #(
   parameter WIDTH = 8
)(
   // Clock and reset
   input  wire             aclk,
   input  wire             aresetn,
   // Raw inputs and conditioned outputs
   input  wire [WIDTH-1:0] din,
   output wire [WIDTH-1:0] lvl,
   output wire [WIDTH-1:0] rise,
   output wire [WIDTH-1:0] fall
);
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : g_bit
         reg s1;
         reg s2;
         reg s3;
         // Two stages for metastability, third only for edge history
         always @(posedge aclk)
         begin
            if (!aresetn)
            begin
               s1 <= 1'b0;
               s2 <= 1'b0;
               s3 <= 1'b0;
            end
            else
            begin
               s1 <= din[i];
               s2 <= s1;
               s3 <= s2;
            end
         end
         // Edges come from stages two and three, never stage one
         assign lvl[i]  = s2;
         assign rise[i] = s2 & ~s3;
         assign fall[i] = ~s2 & s3;
      end
   endgenerate
endmodule
`default_nettype wire

// ### wot_timing.v
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "wot_consts.vh"
module wot_timing (
   // Clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // AXI4-Lite write address
   input  wire [31:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   // AXI4-Lite write data
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   // AXI4-Lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // AXI4-Lite read address
   input  wire [31:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   // AXI4-Lite read data
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   // Trigger and clock inputs
   input  wire [3:0]  gpt_in,
   input  wire        ext_base_clock,
   input  wire        ext_update_strobe,
   input  wire        input_reference_event,
   input  wire        input_start_event,
   // General purpose terminal drive
   output reg  [3:0]  gpt_out,
   output reg  [3:0]  gpt_oe_n,
   // Update strobes to output modules
   output reg         output_update_strobe,
   output wire [3:0]  channel_update
);
   // Bus slave state
   reg        aw_ok;
   reg [5:0]  aw_addr;
   reg        w_ok;
   reg [31:0] w_data;
   reg [3:0]  w_strb;
   // Configuration registers
   reg [31:0] timebase_cfg;
   reg [31:0] divisor;
   reg [31:0] start_cfg;
   reg [31:0] start_delay;
   reg [31:0] start_time;
   reg [31:0] hold_cfg;
   reg [31:0] route_cfg;
   // Engine state
   reg [1:0]  state;
   reg [31:0] phase_acc;
   reg [31:0] time_now;
   reg [31:0] div_cnt;
   reg [31:0] dly_cnt;
   reg [31:0] upd_count;
   reg        start_pulse;
   reg        hold_seen;
   // Combinational nets
   wire        wr_en;
   wire        arm_cmd;
   wire        sw_cmd;
   wire        stop_cmd;
   wire [7:0]  raw_in;
   wire [7:0]  s_lvl;
   wire [7:0]  s_rise;
   wire [7:0]  s_fall;
   wire [1:0]  tb_sel;
   wire        strobe_ext;
   wire        trig_en;
   wire [2:0]  start_src;
   wire [1:0]  start_idx;
   wire        start_fall;
   wire        hold_en;
   wire        hold_internal;
   wire [1:0]  hold_idx;
   wire        hold_low;
   wire        hold_raw;
   wire        hold_act;
   wire [32:0] phase_sum;
   wire        base_tick;
   wire [31:0] div_last;
   wire        int_fire;
   wire        ext_fire;
   reg         src_edge;
   reg         start_event;
   reg [31:0]  inc;
   reg [31:0]  rd_mux;
   reg         rd_hit;

   // Byte-lane merge for partial writes
   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer k;
      begin
         merge = old;
         for (k = 0; k < 4; k = k + 1)
            if (strb[k])
               merge[k*8 +: 8] = nw[k*8 +: 8];
      end
   endfunction

   // Outside signals enter through the synchroniser
   assign raw_in = {input_start_event, input_reference_event, ext_update_strobe,
                    ext_base_clock, gpt_in};
   wot_sync #(
      .WIDTH (8)
   ) i_wot_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .din     (raw_in),
      .lvl     (s_lvl),
      .rise    (s_rise),
      .fall    (s_fall)
   );

   // Field decode
   assign tb_sel        = timebase_cfg[`WOT_TB_SEL_MSB:`WOT_TB_SEL_LSB];
   assign strobe_ext    = timebase_cfg[`WOT_TB_STROBE_EXT];
   assign trig_en       = start_cfg[0];
   assign start_src     = start_cfg[3:1];
   assign start_idx     = start_cfg[5:4];
   assign start_fall    = start_cfg[6];
   assign hold_en       = hold_cfg[0];
   assign hold_internal = hold_cfg[1];
   assign hold_idx      = hold_cfg[3:2];
   assign hold_low      = hold_cfg[4];

   // Bus handshakes; one write and one read in flight
   assign s_axi_awready = ~aw_ok & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_ok & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign wr_en         = aw_ok & w_ok & ~s_axi_bvalid;
   assign arm_cmd  = wr_en & (aw_addr == `WOT_ADDR_CTRL) & w_strb[0] & w_data[`WOT_CTRL_ARM];
   assign sw_cmd   = wr_en & (aw_addr == `WOT_ADDR_CTRL) & w_strb[0]
                     & w_data[`WOT_CTRL_SW_START];
   assign stop_cmd = wr_en & (aw_addr == `WOT_ADDR_CTRL) & w_strb[0] & w_data[`WOT_CTRL_STOP];

   // Base rate pick, fastest at reset
   always @*
   begin
      case (tb_sel)
         `WOT_TB_13M1072: inc = `WOT_INC_13M1072;
         `WOT_TB_12M8:    inc = `WOT_INC_12M8;
         `WOT_TB_10M:     inc = `WOT_INC_10M;
         default:         inc = 32'h00000000;
      endcase
   end

   // Base clock ticks; external base only sampled, never driven out
   assign phase_sum = {1'b0, phase_acc} + {1'b0, inc};
   assign base_tick = (tb_sel == `WOT_TB_EXTERNAL) ? s_rise[4] : phase_sum[32];

   // Hold gate source and active level
   assign hold_raw = hold_internal ? s_lvl[6] : s_lvl[hold_idx];
   assign hold_act = hold_en & (hold_raw ^ hold_low);

   // Integer divider, zero treated as one
   assign div_last = (divisor == 32'h00000000) ? 32'h00000000 : divisor - 32'h00000001;
   // Onboard strobe: divider frozen while held, resumes on release
   assign int_fire = ~strobe_ext & base_tick & ~hold_act & (div_cnt >= div_last);
   // Outside strobe: edges during hold dropped
   assign ext_fire = strobe_ext & s_rise[5] & ~hold_act;

   // Start source and edge selection
   always @*
   begin
      case (start_src)
         `WOT_SRC_SOFTWARE: src_edge = sw_cmd;
         `WOT_SRC_TERMINAL: src_edge = start_fall ? s_fall[start_idx] : s_rise[start_idx];
         `WOT_SRC_IN_REF:   src_edge = start_fall ? s_fall[6] : s_rise[6];
         `WOT_SRC_IN_START: src_edge = start_fall ? s_fall[7] : s_rise[7];
         `WOT_SRC_TIME:     src_edge = (time_now == start_time);
         default:           src_edge = 1'b0;
      endcase
      // Without a trigger, software command starts
      start_event = trig_en ? src_edge : sw_cmd;
   end

   // Bus slave: address and data taken in either order
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_ok        <= 1'b0;
         aw_addr      <= 6'h00;
         w_ok         <= 1'b0;
         w_data       <= 32'h00000000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `WOT_RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rresp  <= `WOT_RESP_OKAY;
         s_axi_rdata  <= 32'h00000000;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_ok   <= 1'b1;
            aw_addr <= s_axi_awaddr[5:0];
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_ok   <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_en)
         begin
            aw_ok        <= 1'b0;
            w_ok         <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr[1:0] == 2'h0 && aw_addr <= `WOT_ADDR_UPD_COUNT)
                            ? `WOT_RESP_OKAY : `WOT_RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? `WOT_RESP_OKAY : `WOT_RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // Read mux; unmapped reads return zero with an error
   always @*
   begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b1;
      case (s_axi_araddr[5:0])
         `WOT_ADDR_CTRL:        rd_mux = 32'h00000000;
         `WOT_ADDR_STATUS:      rd_mux = {28'h0000000, hold_seen, hold_act, state};
         `WOT_ADDR_TIMEBASE:    rd_mux = timebase_cfg;
         `WOT_ADDR_DIVISOR:     rd_mux = divisor;
         `WOT_ADDR_START_CFG:   rd_mux = start_cfg;
         `WOT_ADDR_START_DELAY: rd_mux = start_delay;
         `WOT_ADDR_START_TIME:  rd_mux = start_time;
         `WOT_ADDR_HOLD_CFG:    rd_mux = hold_cfg;
         `WOT_ADDR_ROUTE:       rd_mux = route_cfg;
         `WOT_ADDR_TIME_NOW:    rd_mux = time_now;
         `WOT_ADDR_UPD_COUNT:   rd_mux = upd_count;
         default:               rd_hit = 1'b0;
      endcase
   end

   // Configuration writes
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         timebase_cfg <= `WOT_TIMEBASE_RST;
         divisor      <= `WOT_DIVISOR_RST;
         start_cfg    <= `WOT_START_CFG_RST;
         start_delay  <= 32'h00000000;
         start_time   <= 32'h00000000;
         hold_cfg     <= `WOT_HOLD_CFG_RST;
         route_cfg    <= `WOT_ROUTE_RST;
      end
      else if (wr_en)
      begin
         case (aw_addr)
            `WOT_ADDR_TIMEBASE:    timebase_cfg <= merge(timebase_cfg, w_data, w_strb) & 32'h7;
            `WOT_ADDR_DIVISOR:     divisor      <= merge(divisor, w_data, w_strb);
            `WOT_ADDR_START_CFG:   start_cfg    <= merge(start_cfg, w_data, w_strb) & 32'h7f;
            `WOT_ADDR_START_DELAY: start_delay  <= merge(start_delay, w_data, w_strb);
            `WOT_ADDR_START_TIME:  start_time   <= merge(start_time, w_data, w_strb);
            `WOT_ADDR_HOLD_CFG:    hold_cfg     <= merge(hold_cfg, w_data, w_strb) & 32'h1f;
            `WOT_ADDR_ROUTE:       route_cfg    <= merge(route_cfg, w_data, w_strb) & 32'h7f;
            default:               route_cfg    <= route_cfg;
         endcase
      end
   end

   // Free running time reference and base phase
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         time_now  <= 32'h00000000;
         phase_acc <= 32'h00000000;
      end
      else
      begin
         time_now  <= time_now + 32'h00000001;
         phase_acc <= phase_sum[31:0];
      end
   end

   // Generation sequencer
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         state                <= `WOT_ST_IDLE;
         div_cnt              <= 32'h00000000;
         dly_cnt              <= 32'h00000000;
         upd_count            <= 32'h00000000;
         start_pulse          <= 1'b0;
         output_update_strobe <= 1'b0;
         hold_seen            <= 1'b0;
      end
      else
      begin
         start_pulse          <= 1'b0;
         output_update_strobe <= 1'b0;
         // Sticky hold flag; a new hold wins over the clearing arm
         if (state == `WOT_ST_RUN && hold_act)
            hold_seen <= 1'b1;
         else if (arm_cmd)
            hold_seen <= 1'b0;
         case (state)
            `WOT_ST_IDLE:
            begin
               if (start_event && !trig_en)
               begin
                  start_pulse <= 1'b1;
                  dly_cnt     <= start_delay;
                  div_cnt     <= 32'h00000000;
                  state       <= strobe_ext ? `WOT_ST_RUN : `WOT_ST_DELAY;
               end
               else if (arm_cmd)
               begin
                  upd_count <= 32'h00000000;
                  state     <= `WOT_ST_ARMED;
               end
            end
            `WOT_ST_ARMED:
            begin
               if (stop_cmd)
                  state <= `WOT_ST_IDLE;
               else if (start_event)
               begin
                  start_pulse <= 1'b1;
                  dly_cnt     <= start_delay;
                  div_cnt     <= 32'h00000000;
                  state       <= strobe_ext ? `WOT_ST_RUN : `WOT_ST_DELAY;
               end
            end
            `WOT_ST_DELAY:
            begin
               // Delay counted in base ticks; first update at its end
               if (stop_cmd)
                  state <= `WOT_ST_IDLE;
               else if (base_tick)
               begin
                  if (dly_cnt == 32'h00000000)
                  begin
                     state <= `WOT_ST_RUN;
                     if (!hold_act)
                     begin
                        output_update_strobe <= 1'b1;
                        upd_count            <= upd_count + 32'h00000001;
                     end
                  end
                  else
                     dly_cnt <= dly_cnt - 32'h00000001;
               end
            end
            `WOT_ST_RUN:
            begin
               if (stop_cmd)
                  state <= `WOT_ST_IDLE;
               else
               begin
                  // Hold checked per update; issued strobe completes
                  if (int_fire || ext_fire)
                  begin
                     output_update_strobe <= 1'b1;
                     upd_count            <= upd_count + 32'h00000001;
                  end
                  if (int_fire)
                     div_cnt <= 32'h00000000;
                  else if (base_tick && !hold_act && !strobe_ext)
                     div_cnt <= div_cnt + 32'h00000001;
               end
            end
            default:
               state <= `WOT_ST_IDLE;
         endcase
      end
   end

   // Every channel of the task sees the same strobe
   assign channel_update = {4{output_update_strobe}};

   // Terminal routing; start wins a shared pin
   genvar t;
   generate
      for (t = 0; t < 4; t = t + 1)
      begin : g_term
         wire strobe_sel;
         wire start_sel;
         assign strobe_sel = route_cfg[0] & (route_cfg[2:1] == t);
         assign start_sel  = route_cfg[4] & (route_cfg[6:5] == t);
         always @(posedge aclk)
         begin
            if (!aresetn)
            begin
               gpt_out[t]  <= 1'b0;
               gpt_oe_n[t] <= 1'b1;
            end
            else
            begin
               gpt_oe_n[t] <= ~(strobe_sel | start_sel);
               if (start_sel)
                  gpt_out[t] <= start_pulse;
               else if (strobe_sel)
                  gpt_out[t] <= output_update_strobe ^ route_cfg[3];
               else
                  gpt_out[t] <= 1'b0;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ### wot_timing_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module wot_timing_assertions (
   // Clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // Register bus handshakes
   input wire logic       s_axi_awvalid,
   input wire logic       s_axi_awready,
   input wire logic       s_axi_wvalid,
   input wire logic       s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic       s_axi_bvalid,
   input wire logic       s_axi_bready,
   input wire logic       s_axi_arvalid,
   input wire logic       s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic       s_axi_rvalid,
   input wire logic       s_axi_rready,
   // Update strobes
   input wire logic       output_update_strobe,
   input wire logic [3:0] channel_update
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Answers waiting for the master
   sequence s_b_wait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   sequence s_r_wait;
      s_axi_rvalid && !s_axi_rready;
   endsequence

   a_chan_together: assert property (
      channel_update == {4{output_update_strobe}})
      else $error("channel update differs from strobe");
   a_bresp_hold: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
   a_rdata_hold: assert property (s_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp))
      else $error("read data dropped early");
   a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   a_b_cause: assert property ($rose(s_axi_bvalid) |->
      $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready, 2))
      else $error("write response without a transfer");
   a_r_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
      else $error("read data without an address");
   a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
endmodule
`default_nettype wire

// ### wot_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module wot_far_side (
   // Clock
   input wire logic       aclk,
   // Strobes from the block
   input wire logic [3:0] channel_update,
   // Trigger and clock sources
   output logic [3:0]     gpt_in,
   output logic           ext_base_clock,
   output logic           ext_update_strobe,
   output logic           input_reference_event,
   output logic           input_start_event
);
   integer n_upd [4];

   // Quiet sources at time zero
   initial
   begin
      {gpt_in, ext_base_clock, ext_update_strobe, input_reference_event,
       input_start_event} = 8'h00;
      n_upd = '{default: 0};
   end
   // Outside base clock runs free at half rate
   always @(posedge aclk) ext_base_clock <= ~ext_base_clock;
   // Each channel counted alone so a lagging one shows
   always @(posedge aclk)
      for (int m = 0; m < 4; m++) if (channel_update[m] === 1'b1) n_upd[m] <= n_upd[m] + 1;
   task set_gpt(input integer i, input logic v);
      @(posedge aclk) gpt_in[i] <= v;
   endtask
   task set_src(input integer s, input logic v);
      @(posedge aclk);
      case (s)
         1: gpt_in[0] <= v;
         2: input_reference_event <= v;
         default: input_start_event <= v;
      endcase
   endtask
   // Wide pulses so the synchroniser cannot miss one
   task ext_pulses(input integer n);
      repeat (n)
      begin
         @(posedge aclk) ext_update_strobe <= 1'b1;
         repeat (3) @(posedge aclk);
         ext_update_strobe <= 1'b0;
         repeat (3) @(posedge aclk);
      end
   endtask
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "wot_consts.vh"
module tb;
   // Bus and block signals
   logic        aclk = 0, aresetn = 0;
   logic [31:0] s_axi_awaddr = 0, s_axi_wdata = 0, s_axi_araddr = 0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic        s_axi_arvalid = 0, s_axi_rready = 0;
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire  [1:0]  s_axi_bresp, s_axi_rresp;
   wire  [31:0] s_axi_rdata;
   wire  [3:0]  gpt_in, gpt_out, gpt_oe_n, channel_update;
   wire         ext_base_clock, ext_update_strobe, input_reference_event, input_start_event;
   wire         output_update_strobe;
   integer      n_fail = 0, compares = 0, n_str = 0, r_str = 0, r_st = 0;
   integer      i, k, c, s0, s1;
   logic [31:0] d;
   logic [1:0]  rsp;
   logic [5:0]  ra [5] = '{6'h08, 6'h0c, 6'h10, 6'h1c, 6'h20};
   logic [31:0] rv [5] = '{`WOT_TIMEBASE_RST, `WOT_DIVISOR_RST, `WOT_START_CFG_RST,
                           `WOT_HOLD_CFG_RST, `WOT_ROUTE_RST};
   integer      er [4] = '{262, 256, 200, 250};

   wot_timing i_wot_timing (.*);
   wot_far_side i_wot_far_side (.*);

   initial forever #20 aclk = ~aclk;
   // Strobe and routed terminal counters
   always @(posedge aclk)
   begin
      if (output_update_strobe === 1'b1) n_str <= n_str + 1;
      if (gpt_out[1] === 1'b1 && gpt_oe_n[1] === 1'b0) r_str <= r_str + 1;
      if (gpt_out[3] === 1'b1 && gpt_oe_n[3] === 1'b0) r_st <= r_st + 1;
   end

   task chk(input [31:0] got, input [31:0] exp);
      compares = compares + 1;
      if (got !== exp)
      begin
         n_fail = n_fail + 1;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Jittered base ticks need a small slack
   task near(input integer v, input integer e, input integer tol);
      chk({31'h0, v >= e - tol && v <= e + tol}, 32'h1);
   endtask
   task print_verdict;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task tmo;
      chk(32'h0, 32'h1);
      print_verdict;
   endtask
   task cyc(input integer n);
      repeat (n) @(posedge aclk);
   endtask
   // Bus write: both halves offered, each dropped once taken
   task wr(input [5:0] a, input [31:0] v);
      integer j;
      @(posedge aclk);
      s_axi_awaddr <= {26'h0, a};
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (j = 0; j < 64 && s_axi_bvalid !== 1'b1; j++)
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      if (j == 64) tmo;
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task rd(input [5:0] a);
      integer j;
      @(posedge aclk);
      s_axi_araddr <= {26'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (j = 0; j < 64 && s_axi_rvalid !== 1'b1; j++)
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      if (j == 64) tmo;
      d = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task st;
      rd(`WOT_ADDR_STATUS);
   endtask

   initial
   begin
      cyc(2);
      aresetn <= 1'b1;
      // Reset values and an unmapped place
      for (i = 0; i < 5; i++)
      begin
         rd(ra[i]);
         chk(d, rv[i]);
      end
      rd(6'h3c);
      chk(rsp, `WOT_RESP_SLVERR);
      wr(6'h3c, 32'h5);
      chk(rsp, `WOT_RESP_SLVERR);
      $display("test registers done");
      // Each base rate, outside base last, divided by four, strobe routed
      wr(`WOT_ADDR_ROUTE, 32'h3);
      wr(`WOT_ADDR_DIVISOR, 32'h4);
      for (i = 0; i < 4; i++)
      begin
         wr(`WOT_ADDR_CTRL, 32'h4);
         wr(`WOT_ADDR_TIMEBASE, i);
         wr(`WOT_ADDR_CTRL, 32'h2);
         cyc(40);
         st;
         chk(d[1:0], `WOT_ST_RUN);
         s0 = n_str;
         s1 = r_str;
         cyc(2000);
         near(n_str - s0, er[i], 1);
         near(r_str - s1, n_str - s0, 1);
      end
      chk(gpt_oe_n[1], 1'b0);
      $display("test rates done");
      // Hold gate at both levels
      for (i = 0; i < 2; i++)
      begin
         wr(`WOT_ADDR_HOLD_CFG, 32'h9 | (i << 4));
         i_wot_far_side.set_gpt(2, !i);
         cyc(10);
         s0 = n_str;
         cyc(200);
         chk(n_str - s0, 0);
         st;
         chk(d[2], 1'b1);
         i_wot_far_side.set_gpt(2, i);
         cyc(60);
         chk(n_str - s0 > 0, 1);
      end
      wr(`WOT_ADDR_HOLD_CFG, 32'h0);
      $display("test hold done");
      // Outside strobe: edges in a hold are lost
      wr(`WOT_ADDR_CTRL, 32'h4);
      wr(`WOT_ADDR_TIMEBASE, 32'h4);
      wr(`WOT_ADDR_CTRL, 32'h2);
      cyc(10);
      s0 = n_str;
      i_wot_far_side.ext_pulses(3);
      cyc(10);
      chk(n_str - s0, 3);
      wr(`WOT_ADDR_HOLD_CFG, 32'h9);
      i_wot_far_side.set_gpt(2, 1'b1);
      cyc(10);
      s0 = n_str;
      i_wot_far_side.ext_pulses(2);
      cyc(10);
      chk(n_str - s0, 0);
      i_wot_far_side.set_gpt(2, 1'b0);
      cyc(40);
      chk(n_str - s0, 0);
      i_wot_far_side.ext_pulses(1);
      cyc(10);
      chk(n_str - s0, 1);
      wr(`WOT_ADDR_HOLD_CFG, 32'h0);
      $display("test outside strobe done");
      // Start sources on both edges, start routed
      wr(`WOT_ADDR_TIMEBASE, 32'h2);
      wr(`WOT_ADDR_ROUTE, 32'h70);
      for (i = 1; i < 4; i++)
         for (k = 0; k < 2; k++)
         begin
            wr(`WOT_ADDR_CTRL, 32'h4);
            wr(`WOT_ADDR_START_CFG, 1 | (i << 1) | (k << 6));
            wr(`WOT_ADDR_CTRL, 32'h1);
            st;
            chk(d[1:0], `WOT_ST_ARMED);
            s1 = r_st;
            i_wot_far_side.set_src(i, 1'b1);
            cyc(8);
            st;
            chk(d[1], !k);
            i_wot_far_side.set_src(i, 1'b0);
            cyc(8);
            st;
            chk(d[1], 1'b1);
            chk(r_st - s1, 1);
         end
      $display("test start sources done");
      // Time trigger
      wr(`WOT_ADDR_CTRL, 32'h4);
      rd(`WOT_ADDR_TIME_NOW);
      wr(`WOT_ADDR_START_TIME, d + 150);
      wr(`WOT_ADDR_START_CFG, 32'h9);
      wr(`WOT_ADDR_CTRL, 32'h1);
      cyc(60);
      st;
      chk(d[1:0], `WOT_ST_ARMED);
      cyc(150);
      st;
      chk(d[1], 1'b1);
      $display("test time start done");
      // Start delay of 40 at 10 MHz; first strobe on the 41st base tick
      wr(`WOT_ADDR_CTRL, 32'h4);
      wr(`WOT_ADDR_START_CFG, 32'h0);
      wr(`WOT_ADDR_DIVISOR, 32'h1);
      wr(`WOT_ADDR_START_DELAY, 32'd40);
      s0 = n_str;
      wr(`WOT_ADDR_CTRL, 32'h2);
      for (c = 0; c < 300 && n_str == s0; c++) @(posedge aclk);
      near(c, 102, 4);
      cyc(1);
      for (k = 0; k < 4; k++) chk(i_wot_far_side.n_upd[k], n_str);
      $display("test start delay done");
      print_verdict;
   end
endmodule
bind wot_timing wot_timing_assertions i_wot_timing_assertions (.*);
`default_nettype wire
